// ===== common/ulps_pkg.sv
// shared constants, types and register map of the low-power / serial mode block
package ulps_pkg;

	// ****************************************************************
	// register byte addresses on the wishbone bus
	// ****************************************************************
	localparam logic [7:0] ULPS_ADR_FUNCTION_CONTROL_REG  = 8'h00; // function_control_reg
	localparam logic [7:0] ULPS_ADR_INTERFACE_CONTROL_REG  = 8'h04; // interface_control_reg
	localparam logic [7:0] ULPS_ADR_INT_MASK   = 8'h08; // interrupt mask
	localparam logic [7:0] ULPS_ADR_INT_STATUS = 8'h0c; // sticky change flags, write 1 to clear
	localparam logic [7:0] ULPS_ADR_MODE_STAT  = 8'h10; // current bus mode, read only

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int ULPS_FUNC_ACTIVE_N_BIT = 6; // phy_active_n_ctl
	localparam int ULPS_INTF_SIX_BIT      = 0; // six_wire_serial_select
	localparam int ULPS_INTF_THREE_BIT    = 1; // three_wire_serial_select
	localparam int ULPS_INTF_KEEP_BIT     = 3; // clock_keep_running

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic ULPS_ACTIVE_N_RST = 1'b1; // awake after reset
	localparam logic ULPS_SIX_RST      = 1'b0;
	localparam logic ULPS_THREE_RST    = 1'b0;
	localparam logic ULPS_KEEP_RST     = 1'b0;
	localparam logic ULPS_MASK_RST     = 1'b1; // every source unmasked

	// ****************************************************************
	// types
	// ****************************************************************
	// bus mode of the ulpi data lines
	typedef enum logic [1:0] {
		ULPS_SYNC,
		ULPS_LOW_POWER,
		ULPS_SIX_PIN,
		ULPS_THREE_PIN
	} ulps_mode_t;

	// what the analog receiver reports
	typedef struct packed {
		logic [1:0] line_state;          // line state bits
		logic       serial_rx_plus_line; // single-ended dp
		logic       serial_rx_minus_line; // single-ended dm
		logic       serial_rx_diff_data; // differential receiver
		logic       rx_single_ended_zero; // both lines low
	} ulps_analog_rx_t;

	// what goes to the analog transmitter in the serial modes
	typedef struct packed {
		logic tx_enable;                   // drive the usb lines
		logic serial_tx_diff_data;         // differential data
		logic serial_tx_single_ended_zero; // force se0
	} ulps_serial_tx_t;

endpackage

// ===== rtl/ulps_int_tracker.sv
// interrupt source change detection, sticky flags, mask gating and wake snapshot
`timescale 1ns/100ps
`default_nettype none
module ulps_int_tracker
	import ulps_pkg::*;
#(
	parameter int SRC_W = 4
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// interrupt sources and software control
	input  wire logic [SRC_W-1:0] int_src,
	input  wire logic [SRC_W-1:0] int_mask,
	input  wire logic             clear_wr,
	input  wire logic [SRC_W-1:0] clear_bits,
	input  wire logic             snap_take,
	// results
	output logic      [SRC_W-1:0] int_status,
	output logic                  int_pending,
	output logic                  change_persists
);

	logic [SRC_W-1:0] src_prev; // sources one cycle ago
	logic [SRC_W-1:0] src_snap; // sources when low-power mode was entered

	// previous value for change detection
	always_ff @(posedge mclk) begin
		if (rst) begin
			// take the present level, so a source already high at reset is no change
			src_prev <= int_src;
		end else begin
			src_prev <= int_src;
		end
	end

	// sticky flags; a change in the clearing cycle survives
	always_ff @(posedge mclk) begin
		if (rst) begin
			int_status <= '0;
		end else begin
			int_status <= (int_status & ~(clear_wr ? clear_bits : '0)) | (int_src ^ src_prev);
		end
	end

	// snapshot at entry, compared against at exit
	always_ff @(posedge mclk) begin
		if (rst) begin
			src_snap <= '0;
		end else if (snap_take) begin
			src_snap <= int_src;
		end
	end

	// any unmasked flag raises the interrupt line
	assign int_pending = |(int_status & int_mask);
	// a change that went away again does not count
	assign change_persists = |((int_src ^ src_snap) & int_mask);

endmodule
`default_nettype wire

// ===== rtl/ulps_pin_map.sv
// data bus mapping for synchronous, low-power, six-wire and three-wire modes
`timescale 1ns/100ps
`default_nettype none
module ulps_pin_map
	import ulps_pkg::*;
(
	// mode and sources
	input  wire ulps_mode_t      mode,
	input  wire ulps_analog_rx_t rx,
	input  wire logic            int_line,
	input  wire logic [7:0]      data_in,
	// bus drive
	output logic      [7:0]      data_out,
	output logic      [7:0]      data_oe,
	// toward the analog transmitter
	output ulps_serial_tx_t      tx
);

	// pure wiring: line state reaches the bus with no flop in the way
	always_comb begin
		data_out = 8'h00; // unused lines stay low
		data_oe  = 8'h00;
		tx       = '0;
		case (mode)
			ULPS_LOW_POWER: begin
				data_oe     = 8'hff; // every line is an output
				data_out[0] = rx.line_state[0];
				data_out[1] = rx.line_state[1];
				data_out[3] = int_line;
			end
			ULPS_SIX_PIN: begin
				data_oe     = 8'hf8; // bits 2..0 are link inputs
				tx.tx_enable                   = data_in[0];
				tx.serial_tx_diff_data         = data_in[1];
				tx.serial_tx_single_ended_zero = data_in[2];
				data_out[3] = int_line;
				data_out[4] = rx.serial_rx_plus_line;
				data_out[5] = rx.serial_rx_minus_line;
				data_out[6] = rx.serial_rx_diff_data;
			end
			ULPS_THREE_PIN: begin
				tx.tx_enable = data_in[0];
				if (data_in[0]) begin
					// link owns bits 1 and 2 while transmitting
					data_oe = 8'hf8;
					tx.serial_tx_diff_data         = data_in[1];
					tx.serial_tx_single_ended_zero = data_in[2];
				end else begin
					data_oe     = 8'hfe;
					data_out[1] = rx.serial_rx_diff_data;
					data_out[2] = rx.rx_single_ended_zero;
				end
				data_out[3] = int_line;
			end
			default: begin
				// synchronous mode: the bus belongs to the transfer logic
				data_out = 8'h00;
				data_oe  = 8'h00;
			end
		endcase
	end

endmodule
`default_nettype wire

// ===== rtl/ulps_mode_ctrl.sv
// mode controller for low-power and serial ulpi bus modes, with wishbone registers
`timescale 1ns/100ps
`default_nettype none
module ulps_mode_ctrl
	import ulps_pkg::*;
#(
	parameter int SRC_W = 4 // number of interrupt sources
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	// ulpi side
	input  wire logic             stp,
	input  wire logic [7:0]       data_in,
	output logic      [7:0]       data_out,
	output logic      [7:0]       data_oe,
	output logic                  dir,
	// analog front end
	input  wire ulps_analog_rx_t  rx,
	input  wire logic [SRC_W-1:0] int_src,
	output ulps_serial_tx_t       tx,
	// clock and wake control
	output logic                  clk_run,
	output logic                  rxcmd_request
);

	// ****************************************************************
	// state
	// ****************************************************************
	ulps_mode_t       mode;          // current bus mode
	ulps_mode_t       next_mode;     // mode for the next cycle
	logic             active_n;      // phy_active_n_ctl
	logic             six_sel;       // six_wire_serial_select
	logic             three_sel;     // three_wire_serial_select
	logic             keep_clk;      // clock_keep_running
	logic [SRC_W-1:0] int_mask;      // 1 = source may interrupt
	logic [SRC_W-1:0] int_status;    // sticky change flags
	logic             int_pending;   // any unmasked flag set
	logic             change_persists; // source differs from entry snapshot
	logic             bus_req;       // new wishbone request this cycle
	logic             wr_req;        // write request
	logic             wr_low;        // write touching byte lane 0
	logic             lp_enter;      // entering low power now
	logic             lp_exit;       // leaving low power now
	logic             serial_exit;   // leaving a serial mode now
	logic [31:0]      next_rdata;    // read data for the addressed register

	// ****************************************************************
	// bus decode
	// ****************************************************************
	// ack is high for exactly one cycle, so a held request is not seen twice
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_req  = bus_req & wb_we_i;
	// every field lives in the low byte, so only lane 0 stores anything
	assign wr_low  = wr_req & wb_sel_i[0];

	// address match helper, used for each register
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
		hit = (adr[7:2] == reg_adr[7:2]);
	endfunction

	// ****************************************************************
	// mode transitions
	// ****************************************************************
	// stp in synchronous mode ends a transfer, so entry waits for it low
	always_comb begin
		next_mode = mode;
		case (mode)
			ULPS_SYNC: begin
				if (!stp) begin
					// serial selects win over sleep if software sets several
					if (six_sel) begin
						next_mode = ULPS_SIX_PIN;
					end else if (three_sel) begin
						next_mode = ULPS_THREE_PIN;
					end else if (!active_n) begin
						next_mode = ULPS_LOW_POWER;
					end
				end
			end
			ULPS_LOW_POWER: begin
				// clk_run stays low until this exit, but mclk keeps running, so stp is seen
				if (stp) begin
					next_mode = ULPS_SYNC;
				end
			end
			ULPS_SIX_PIN: begin
				if (stp) begin
					next_mode = ULPS_SYNC;
				end
			end
			ULPS_THREE_PIN: begin
				if (stp) begin
					next_mode = ULPS_SYNC;
				end
			end
			default: begin
				next_mode = ULPS_SYNC;
			end
		endcase
	end

	assign lp_enter    = (mode == ULPS_SYNC) && (next_mode == ULPS_LOW_POWER);
	assign lp_exit     = (mode == ULPS_LOW_POWER) && (next_mode == ULPS_SYNC);
	assign serial_exit = (mode == ULPS_SIX_PIN || mode == ULPS_THREE_PIN)
		&& (next_mode == ULPS_SYNC);

	// mode register
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode <= ULPS_SYNC;
		end else begin
			mode <= next_mode;
		end
	end

	// dir tracks the mode it is registered with, so both change together
	always_ff @(posedge mclk) begin
		if (rst) begin
			dir <= 1'b0;
		end else begin
			dir <= (next_mode != ULPS_SYNC);
		end
	end

	// stp is held by the link until dir has dropped; entry from sync then waits for it low

	// ****************************************************************
	// control registers
	// ****************************************************************
	// exit sets the request bit back to 1 (awake); hardware wins over a same-cycle write
	always_ff @(posedge mclk) begin
		if (rst) begin
			active_n <= ULPS_ACTIVE_N_RST;
		end else if (lp_exit) begin
			active_n <= 1'b1;
		end else if (wr_low && hit(wb_adr_i, ULPS_ADR_FUNCTION_CONTROL_REG)) begin
			active_n <= wb_dat_i[ULPS_FUNC_ACTIVE_N_BIT];
		end
	end

	// serial selects, cleared again when the link leaves the mode
	always_ff @(posedge mclk) begin
		if (rst) begin
			six_sel   <= ULPS_SIX_RST;
			three_sel <= ULPS_THREE_RST;
		end else if (serial_exit) begin
			six_sel   <= 1'b0;
			three_sel <= 1'b0;
		end else if (wr_low && hit(wb_adr_i, ULPS_ADR_INTERFACE_CONTROL_REG)) begin
			six_sel   <= wb_dat_i[ULPS_INTF_SIX_BIT];
			three_sel <= wb_dat_i[ULPS_INTF_THREE_BIT];
		end
	end

	// clock keep-running bit
	always_ff @(posedge mclk) begin
		if (rst) begin
			keep_clk <= ULPS_KEEP_RST;
		end else if (wr_low && hit(wb_adr_i, ULPS_ADR_INTERFACE_CONTROL_REG)) begin
			keep_clk <= wb_dat_i[ULPS_INTF_KEEP_BIT];
		end
	end

	// interrupt mask
	always_ff @(posedge mclk) begin
		if (rst) begin
			int_mask <= {SRC_W{ULPS_MASK_RST}};
		end else if (wr_low && hit(wb_adr_i, ULPS_ADR_INT_MASK)) begin
			int_mask <= wb_dat_i[SRC_W-1:0];
		end
	end

	// ****************************************************************
	// register read and acknowledge
	// ****************************************************************
	// unmapped addresses read zero and ignore writes, but still ack
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit(wb_adr_i, ULPS_ADR_FUNCTION_CONTROL_REG)) begin
			next_rdata[ULPS_FUNC_ACTIVE_N_BIT] = active_n;
		end else if (hit(wb_adr_i, ULPS_ADR_INTERFACE_CONTROL_REG)) begin
			next_rdata[ULPS_INTF_SIX_BIT]   = six_sel;
			next_rdata[ULPS_INTF_THREE_BIT] = three_sel;
			next_rdata[ULPS_INTF_KEEP_BIT]  = keep_clk;
		end else if (hit(wb_adr_i, ULPS_ADR_INT_MASK)) begin
			next_rdata[SRC_W-1:0] = int_mask;
		end else if (hit(wb_adr_i, ULPS_ADR_INT_STATUS)) begin
			next_rdata[SRC_W-1:0] = int_status;
		end else if (hit(wb_adr_i, ULPS_ADR_MODE_STAT)) begin
			next_rdata[1:0] = mode;
			next_rdata[2]   = dir;
		end
	end

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge mclk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// read data stands with ack
	always_ff @(posedge mclk) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req) begin
			wb_dat_o <= wb_we_i ? 32'h0000_0000 : next_rdata;
		end
	end

	// ****************************************************************
	// interrupt tracking and wake report
	// ****************************************************************
	ulps_int_tracker #(
		.SRC_W (SRC_W)
	) u_int (
		.mclk            (mclk),
		.rst             (rst),
		.int_src         (int_src),
		.int_mask        (int_mask),
		.clear_wr        (wr_low && hit(wb_adr_i, ULPS_ADR_INT_STATUS)),
		.clear_bits      (wb_dat_i[SRC_W-1:0]),
		.snap_take       (lp_enter),
		.int_status      (int_status),
		.int_pending     (int_pending),
		.change_persists (change_persists)
	);

	// one-cycle request to the synchronous side to send an rxcmd
	always_ff @(posedge mclk) begin
		if (rst) begin
			rxcmd_request <= 1'b0;
		end else begin
			rxcmd_request <= lp_exit && change_persists;
		end
	end

	// ****************************************************************
	// interface clock control
	// ****************************************************************
	// in low power the clock stops; serial modes keep it only on request
	always_ff @(posedge mclk) begin
		if (rst) begin
			clk_run <= 1'b1;
		end else begin
			case (next_mode)
				ULPS_SYNC:      clk_run <= 1'b1;
				ULPS_LOW_POWER: clk_run <= 1'b0;
				default:        clk_run <= keep_clk;
			endcase
		end
	end

	// ****************************************************************
	// data bus mapping
	// ****************************************************************
	// unregistered on purpose: line state and serial data must not lag
	ulps_pin_map u_map (
		.mode     (mode),
		.rx       (rx),
		.int_line (int_pending),
		.data_in  (data_in),
		.data_out (data_out),
		.data_oe  (data_oe),
		.tx       (tx)
	);

endmodule
`default_nettype wire

// ===== testbench/ulps_checker.sv
// assertion checker for the low-power and serial bus modes
`timescale 1ns/100ps
`default_nettype none
module ulps_checker
	import ulps_pkg::*;
(
	// clock and reset
	input wire logic            mclk,
	input wire logic            rst,
	// ulpi side
	input wire logic            stp,
	input wire logic [7:0]      data_in,
	input wire logic [7:0]      data_out,
	input wire logic [7:0]      data_oe,
	input wire logic            dir,
	// front end and wake
	input wire ulps_analog_rx_t rx,
	input wire ulps_serial_tx_t tx,
	input wire logic            rxcmd_request
);
	// ********
	// mode seen from the drive pattern
	// ********
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// six-wire and transmitting three-wire look alike, so checks stay common
	wire lp = dir && data_oe == 8'hff;
	wire ser = dir && data_oe != 8'hff;

	a_lp_line_map: assert property (lp |-> data_out[1:0] == rx.line_state
		&& data_out[2] == 1'b0 && data_out[7:4] == 4'h0) else $error("low-power map wrong");
	a_int_driven: assert property (dir |-> data_oe[3] && data_oe[7:4] == 4'hf)
		else $error("interrupt or unused line not driven");
	a_six_rx_map: assert property (ser && data_oe == 8'hf8 && !data_in[0] |->
		data_out[7:4] == {1'b0, rx.serial_rx_diff_data, rx.serial_rx_minus_line,
		rx.serial_rx_plus_line}) else $error("six-wire receive map wrong");
	a_tx_follow: assert property (ser && data_in[0] |->
		tx == {1'b1, data_in[1], data_in[2]}) else $error("transmit bits not passed");
	a_link_release: assert property (ser && data_in[0] |-> data_oe[2:0] == 3'h0)
		else $error("device drives link lines");
	a_three_rx_map: assert property (ser && data_oe == 8'hfe |-> !tx.tx_enable &&
		data_out[2:1] == {rx.rx_single_ended_zero, rx.serial_rx_diff_data})
		else $error("three-wire receive map wrong");
	a_stp_exit: assert property (dir && stp |=> !dir)
		else $error("stop did not leave the mode");
	a_dir_hold: assert property (dir && !stp |=> dir)
		else $error("dir dropped without stop");
	a_wake_pulse: assert property (rxcmd_request |-> !dir && $past(lp) ##1 !rxcmd_request)
		else $error("wake rxcmd at wrong time");

	c_low_power: cover property (lp ##1 !dir);
	c_three_rx: cover property (ser && data_oe == 8'hfe);
	c_link_tx: cover property (ser && data_in[0]);
	c_wake: cover property (rxcmd_request);
endmodule
bind ulps_mode_ctrl ulps_checker i_ulps_checker (.mclk, .rst, .stp, .data_in, .data_out,
	.data_oe, .dir, .rx, .tx, .rxcmd_request);
`default_nettype wire

// ===== testbench/ulps_link_model.sv
// link controller model that drives stop and the link side of the data lines
`timescale 1ns/100ps
`default_nettype none
module ulps_link_model (
	// clock and bench requests
	input wire logic        mclk,
	input wire logic        stop_req,
	input wire logic [2:0]  tx_bits,
	// device side
	input wire logic        dir,
	input wire logic [7:0]  data_out,
	input wire logic [7:0]  data_oe,
	output logic            stp,
	output logic [7:0]      data_in
);
	// ********
	// stop and wire levels
	// ********
	logic [7:0] last;    // last wire level
	logic [7:0] link_en; // lines the link drives
	logic [7:0] link_val;
	// reference clock never stops here, so it runs before any stop
	// stop held from the request until the bus is synchronous again
	always_ff @(posedge mclk) begin
		stp <= stop_req || (stp && dir);
	end
	// link drives all lines low in sync, else only lines the device leaves free
	assign link_en = dir ? (~data_oe & 8'h07) : 8'hff;
	assign link_val = dir ? {5'h00, tx_bits} : 8'h00;
	always_ff @(posedge mclk) begin
		last <= data_in;
	end
	// a line nobody drives flips, so a stale value can never pass
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			data_in[i] = data_oe[i] ? data_out[i] : link_en[i] ? link_val[i] : ~last[i];
		end
	end
endmodule
`default_nettype wire

// ===== testbench/ulps_mode_ctrl_tb.sv
// self-checking bench of the low-power and serial mode controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
module ulps_mode_ctrl_tb import ulps_pkg::*;;
	// ********
	// signals, design and link
	// ********
	logic mclk = 1'b0, rst = 1'b1, stop_req = 1'b0, stp, dir, wb_ack_o, clk_run, rxcmd_request;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00, data_in, data_out, data_oe;
	logic [3:0] wb_sel_i = 4'hf, int_src = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [2:0] tx_bits = 3'h0;
	ulps_analog_rx_t rx = '0;
	ulps_serial_tx_t tx;
	int bad_count = 0, check_count = 0, pulses = 0;

	initial forever #20 mclk = ~mclk;
	// wake rxcmd pulses are one cycle, counted as they pass
	always @(posedge mclk) if (rxcmd_request === 1'b1) pulses++;

	ulps_mode_ctrl #(.SRC_W(4)) i_ulps_mode_ctrl (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stp, .data_in, .data_out,
		.data_oe, .dir, .rx, .int_src, .tx, .clk_run, .rxcmd_request);
	ulps_link_model i_ulps_link_model (.mclk, .stop_req, .tx_bits, .dir, .data_out,
		.data_oe, .stp, .data_in);

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// classic wishbone cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
		do begin @(posedge mclk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin bad_count++; report_and_stop(); end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK("register", e, q)
	endtask
	task automatic wait_dir(input logic v);
		int n;
		n = 0;
		while (dir !== v && n < 20) begin @(posedge mclk); n++; end
		if (n >= 20) begin bad_count++; report_and_stop(); end
		@(negedge mclk);
	endtask
	task automatic drive(input ulps_analog_rx_t r, input logic [2:0] t);
		@(posedge mclk);
		rx <= r; tx_bits <= t;
		@(negedge mclk);
	endtask
	task automatic wake;
		@(posedge mclk) stop_req <= 1'b1;
		@(posedge mclk) stop_req <= 1'b0;
		wait_dir(1'b0);
	endtask

	initial begin
		repeat (5000) @(posedge mclk);
		bad_count++; // hang
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rd(ULPS_ADR_FUNCTION_CONTROL_REG, 32'h40);
		rd(ULPS_ADR_INTERFACE_CONTROL_REG, 32'h0);
		rd(ULPS_ADR_INT_MASK, 32'hf);
		rd(8'h20, 32'h0);
		// stop held in sync keeps the device awake
		@(posedge mclk) stop_req <= 1'b1;
		wb(1'b1, ULPS_ADR_FUNCTION_CONTROL_REG, 32'h0);
		repeat (3) @(posedge mclk);
		stop_req <= 1'b0;
		`CHK("dir", 1'b0, dir)
		wait_dir(1'b1);
		rd(ULPS_ADR_MODE_STAT, 32'h5);
		`CHK("clk_run", 1'b0, clk_run)
		for (int i = 0; i < 4; i++) begin
			drive({i[1:0], 4'h0}, 3'h0);
			`CHK("lp bus", {6'h00, i[1:0]}, data_out)
		end
		@(posedge mclk) int_src <= 4'h1;
		repeat (3) @(negedge mclk);
		`CHK("int", 1'b1, data_out[3])
		wb(1'b1, ULPS_ADR_INT_MASK, 32'he);
		@(negedge mclk);
		`CHK("int masked", 1'b0, data_out[3])
		wb(1'b1, ULPS_ADR_INT_MASK, 32'hf);
		wake();
		rd(ULPS_ADR_FUNCTION_CONTROL_REG, 32'h40);
		`CHK("rxcmd", 1, pulses)
		wb(1'b1, ULPS_ADR_INT_STATUS, 32'hf);
		// a change that vanishes before exit asks for no rxcmd
		wb(1'b1, ULPS_ADR_FUNCTION_CONTROL_REG, 32'h0);
		wait_dir(1'b1);
		@(posedge mclk) int_src <= 4'h3;
		@(posedge mclk) int_src <= 4'h1;
		wake();
		rd(ULPS_ADR_FUNCTION_CONTROL_REG, 32'h40);
		`CHK("no rxcmd", 1, pulses)
		// six-wire mode, every receive and transmit combination
		wb(1'b1, ULPS_ADR_INTERFACE_CONTROL_REG, 32'h1);
		wait_dir(1'b1);
		`CHK("six clk_run", 1'b0, clk_run)
		for (int i = 0; i < 8; i++) begin
			drive({2'b00, i[2:0], 1'b0}, i[2:0]);
			`CHK("six rx", {1'b0, i[0], i[1], i[2]}, data_out[7:4])
			`CHK("six tx", {i[0], i[1], i[2]}, tx)
		end
		wake();
		rd(ULPS_ADR_INTERFACE_CONTROL_REG, 32'h0);
		// three-wire mode with the clock kept running
		wb(1'b1, ULPS_ADR_INTERFACE_CONTROL_REG, 32'ha);
		wait_dir(1'b1);
		`CHK("clk_run", 1'b1, clk_run)
		for (int i = 0; i < 8; i++) begin
			drive({4'h0, i[1], i[2]}, i[2:0]);
			`CHK("three oe", i[0] ? 8'hf8 : 8'hfe, data_oe)
			`CHK("three en", i[0], tx.tx_enable)
			`CHK("three bits", {i[2], i[1]}, i[0] ? {tx.serial_tx_single_ended_zero,
				tx.serial_tx_diff_data} : data_out[2:1])
		end
		wake();
		rd(ULPS_ADR_INTERFACE_CONTROL_REG, 32'h8);
		`CHK("sync oe", 8'h00, data_oe)
		`CHK("sync tx", 3'h0, tx)
		`CHK("sync clk_run", 1'b1, clk_run)
		report_and_stop();
	end
endmodule
`default_nettype wire
